// file: verilog/rsq_consts.svh
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH
`define RSQ_CLK_NS 40
`define RSQ_SCLK_HALF_NS 480
`define RSQ_SCLK_HALF_CYC (`RSQ_SCLK_HALF_NS / `RSQ_CLK_NS)
`define RSQ_CAL_NS 8000
`define RSQ_CAL_CYC (`RSQ_CAL_NS / `RSQ_CLK_NS)
`define RSQ_A_CFG 8'h00
`define RSQ_A_XFER 8'h01
`define RSQ_A_FEEDBACK_DIVIDER 8'h56
`define RSQ_A_CALEN 8'h5a
`define RSQ_A_LOCK 8'h90
`define RSQ_A_BUSY 8'hba
`define RSQ_A_WIPE 8'hff
`define RSQ_A_TOP 8'h72
`define RSQ_A_BOT 8'h10
`define RSQ_CFG_RST_MASK 8'h81
`define RSQ_CFG_ASC_HI 5
`define RSQ_CFG_ASC_LO 2
`define RSQ_CFG_4W_HI 4
`define RSQ_CFG_4W_LO 3
`define RSQ_XFER_SINGLE 7
`define RSQ_CALEN_BIT 6
`define RSQ_WIPE_BIT 0
`define RSQ_H_CTRL 8'h00
`define RSQ_H_STAT 8'h01
`define RSQ_H_STRAP 8'h02
`define RSQ_CTRL_START 0
`define RSQ_CTRL_SINGLE 1
`endif

// file: verilog/rsq_pkg.sv
package rsq_pkg;
  typedef enum logic [1:0] {D_IDLE, D_INSTR, D_DATA, D_HOLD} rsq_dev_e;
  typedef enum logic [2:0] {H_IDLE, H_RST, H_XF, H_CF, H_LD, H_PB, H_PL, H_DONE} rsq_seq_e;
  typedef enum logic [1:0] {E_IDLE, E_RUN, E_END, E_GAP} rsq_eng_e;

  typedef struct packed {
    rsq_dev_e st;
    logic [2:0] cs_s, ck_s, di_s, rf_s;
    logic [2:0][3:0] sp_s;
    logic cs_f, ck_f, di_f, rf_f;
    logic [3:0] sp_f;
    logic [15:0] sh;
    logic [3:0] cnt;
    logic rw, sel, dout, drv, pend_soft, pend_full;
    logic [7:0] addr, osh, cal;
    logic [255:0][7:0] regs;
  } rsq_dev_s;

  typedef struct packed {
    rsq_seq_e st;
    rsq_eng_e eng;
    logic [2:0] di_s;
    logic di_f, csel, sclk, dout, doe, rw, stream, fin, single;
    logic [7:0] div, rx, cur, rdata;
    logic [3:0] strap;
    logic [23:0] sh;
    logic [4:0] bitn;
  } rsq_host_s;

  // level filter: accept a change once second and third stage agree
  function automatic logic sync_filt(input logic [2:0] s, input logic f);
    return (s[1] == s[2]) ? s[2] : f;
  endfunction
endpackage

// file: verilog/rsq_spi_if.sv
`timescale 1ns/1ps
interface rsq_spi_if;
  logic cs_n;
  logic sclk;
  logic host_dio_o;
  logic host_dio_oe;
  logic dev_dio_o;
  logic dev_dio_oe;
  logic sdo_o;
  logic sdo_oe;
  wire sdio;
  wire sdo_line;
  // a constant 1 stands in for the board pull-up resistor when nobody drives
  assign sdio = dev_dio_oe ? dev_dio_o : (host_dio_oe ? host_dio_o : 1'b1);
  assign sdo_line = sdo_oe ? sdo_o : 1'b1;
  modport dev(input cs_n, input sclk, input sdio, output dev_dio_o, output dev_dio_oe, output sdo_o, output sdo_oe);
  modport host(output cs_n, output sclk, output host_dio_o, output host_dio_oe, input sdio);
endinterface

// file: verilog/rsq_device.sv
`timescale 1ns/1ps
`include "rsq_consts.svh"
module rsq_device (
  input wire logic ref_clk,
  input wire logic resetn,
  rsq_spi_if.dev spi,
  input wire logic id_strap_bit0,
  input wire logic id_strap_bit1,
  input wire logic id_strap_bit2,
  input wire logic id_strap_bit3,
  input wire logic reference_clock_input,
  output logic loop_lock_flag,
  output logic cal_busy
);
  rsq_pkg::rsq_dev_s q, d;
  logic cs_now, ck_now, di_now, rf_now;
  logic [3:0] sp_now;
  logic ck_rise, ck_fall, four_wire, ascend;
  logic [7:0] nxt;
  logic [7:0] wv;

  function automatic logic hits(input logic [15:0] w, input logic [3:0] strap);
    logic addr_ok;
    logic strap_ok;
    logic bcast;
    addr_ok = (w[14:13] == 2'b00) && !w[8];
    strap_ok = (w[12:9] == strap);
    // a write to the port configuration reaches every device on the bus
    bcast = !w[15] && (w[7:0] == `RSQ_A_CFG);
    return addr_ok && (strap_ok || bcast);
  endfunction

  always_comb begin
    d = q;
    wv = 8'h00;
    // every pin passes three stages; a level counts once the last two agree
    cs_now = rsq_pkg::sync_filt(q.cs_s, q.cs_f);
    ck_now = rsq_pkg::sync_filt(q.ck_s, q.ck_f);
    di_now = rsq_pkg::sync_filt(q.di_s, q.di_f);
    rf_now = rsq_pkg::sync_filt(q.rf_s, q.rf_f);
    for (int i = 0; i < 4; i++) begin
      sp_now[i] = rsq_pkg::sync_filt({q.sp_s[2][i], q.sp_s[1][i], q.sp_s[0][i]}, q.sp_f[i]);
    end
    ck_rise = ck_now && !q.ck_f;
    ck_fall = !ck_now && q.ck_f;
    // either ascend bit selects incrementing addresses; both clear means decrement
    ascend = q.regs[`RSQ_A_CFG][`RSQ_CFG_ASC_HI] || q.regs[`RSQ_A_CFG][`RSQ_CFG_ASC_LO];
    nxt = ascend ? q.addr + 8'h01 : q.addr - 8'h01;
    d.cs_s = {q.cs_s[1:0], spi.cs_n};
    d.ck_s = {q.ck_s[1:0], spi.sclk};
    d.di_s = {q.di_s[1:0], spi.sdio};
    d.rf_s = {q.rf_s[1:0], reference_clock_input};
    d.sp_s = {q.sp_s[1:0], {id_strap_bit3, id_strap_bit2, id_strap_bit1, id_strap_bit0}};
    d.cs_f = cs_now;
    d.ck_f = ck_now;
    d.di_f = di_now;
    d.rf_f = rf_now;
    d.sp_f = sp_now;

    // calibration only advances on cycles where the filtered reference clock input is high
    // limitation: calibration time is a fixed count, not a model of the loop
    if (q.cal != 8'h00 && rf_now) begin
      d.cal = q.cal - 8'h01;
      if (q.cal == 8'h01) begin
        d.regs[`RSQ_A_BUSY][0] = 1'b0;
        d.regs[`RSQ_A_LOCK][0] = q.regs[`RSQ_A_CALEN][`RSQ_CALEN_BIT];
      end
    end

    if (cs_now) begin
      // deselect: release the pins and restart the frame
      d.st = rsq_pkg::D_IDLE;
      d.drv = 1'b0;
      if (!q.cs_f) begin
        // resets wait for the frame end so the shifter is never cut mid-byte
        if (q.pend_full) begin
          d.regs = '0;
          d.cal = 8'h00;
        end else if (q.pend_soft) begin
          // the port configuration survives but loses its own request bits
          d.regs = '0;
          d.regs[`RSQ_A_CFG] = q.regs[`RSQ_A_CFG] & ~`RSQ_CFG_RST_MASK;
          d.cal = 8'h00;
        end
        d.pend_full = 1'b0;
        d.pend_soft = 1'b0;
      end
    end else if (q.cs_f) begin
      // a new frame always starts with the instruction word
      d.st = rsq_pkg::D_INSTR;
      d.cnt = 4'h0;
    end else if (ck_rise) begin
      case (q.st)
        rsq_pkg::D_INSTR: begin
          d.sh = {q.sh[14:0], di_now};
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'hf) begin
            d.st = rsq_pkg::D_DATA;
            d.cnt = 4'h0;
            d.rw = d.sh[15];
            d.addr = d.sh[7:0];
            d.sel = hits(d.sh, sp_now);
            // fetch now: the first read bit leaves on the very next falling edge
            d.osh = q.regs[d.sh[7:0]];
          end
        end
        rsq_pkg::D_DATA: begin
          // the shifter is reused for the data byte; only its low half moves
          d.sh[7:0] = {q.sh[6:0], di_now};
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h7) begin
            d.cnt = 4'h0;
            wv = d.sh[7:0];
            if (!q.rw && q.sel) begin
              case (q.addr)
                `RSQ_A_CFG: begin
                  d.regs[`RSQ_A_CFG] = wv;
                  if ((wv & `RSQ_CFG_RST_MASK) == `RSQ_CFG_RST_MASK) begin
                    d.pend_soft = 1'b1;
                  end
                end
                `RSQ_A_WIPE: begin
                  // the wipe restarts the whole map, port configuration included
                  if (wv[`RSQ_WIPE_BIT]) begin
                    d.pend_full = 1'b1;
                  end
                end
                `RSQ_A_BUSY, `RSQ_A_LOCK: begin
                  // status bits belong to the calibration engine; host writes are dropped
                end
                `RSQ_A_FEEDBACK_DIVIDER: begin
                  // a divider write restarts calibration and drops any earlier lock
                  d.regs[`RSQ_A_FEEDBACK_DIVIDER] = wv;
                  d.cal = 8'(`RSQ_CAL_CYC);
                  d.regs[`RSQ_A_BUSY][0] = 1'b1;
                  d.regs[`RSQ_A_LOCK][0] = 1'b0;
                end
                default: begin
                  // every other address is plain storage
                  d.regs[q.addr] = wv;
                end
              endcase
            end
            d.addr = nxt;
            d.osh = q.regs[nxt];
            if (q.regs[`RSQ_A_XFER][`RSQ_XFER_SINGLE]) begin
              // single-register mode: ignore further clocks until chip select rises
              d.st = rsq_pkg::D_HOLD;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (ck_fall && q.st == rsq_pkg::D_DATA && q.rw && q.sel) begin
      // change on the falling edge so the bit is settled at the host's rising edge
      d.dout = q.osh[7];
      d.osh = {q.osh[6:0], 1'b0};
      d.drv = 1'b1;
    end
  end

  // one register for the whole state keeps the reset in one place
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // chip select and data pin idle high: start their filters there, no false edge
      q <= '0;
      q.cs_s <= 3'b111;
      q.cs_f <= 1'b1;
      q.di_s <= 3'b111;
      q.di_f <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // either mode bit selects 4-wire; the data pin then stays an input
  assign four_wire = q.regs[`RSQ_A_CFG][`RSQ_CFG_4W_HI] || q.regs[`RSQ_A_CFG][`RSQ_CFG_4W_LO];
  // read data go to both pins; the mode decides which one is enabled
  assign spi.dev_dio_o = q.dout;
  assign spi.dev_dio_oe = q.drv && !four_wire;
  assign spi.sdo_o = q.dout;
  assign spi.sdo_oe = q.drv && four_wire;
  assign loop_lock_flag = q.regs[`RSQ_A_LOCK][0];
  assign cal_busy = q.regs[`RSQ_A_BUSY][0];
endmodule

// file: verilog/rsq_host.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "rsq_consts.svh"
module rsq_host (
  input wire logic ref_clk,
  input wire logic resetn,
  rsq_spi_if.host spi,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);
  rsq_pkg::rsq_host_s q, d;
  logic tick;
  logic go;
  logic go_rw;
  logic go_stream;
  logic [3:0] go_strap;
  logic [7:0] go_addr;
  logic [7:0] go_byte;

  // instruction word: bits 14, 13 and 8 stay zero, 12..9 carry the strap
  function automatic logic [15:0] instr(input logic rw, input logic [3:0] strap, input logic [7:0] a);
    return {rw, 2'b00, strap, 1'b0, a};
  endfunction

  // power-up image: zero everywhere except the listed registers
  function automatic logic [7:0] image(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      8'h6a, 8'h69: v = 8'h0a;
      8'h66: v = 8'h80;
      8'h64, 8'h63, 8'h5c: v = 8'h1e;
      8'h62: v = 8'h4c;
      8'h61, 8'h55: v = 8'h01;
      8'h60: v = 8'h2b;
      8'h5f: v = 8'h5d;
      8'h5e: v = 8'h32;
      8'h5d: v = 8'h10;
      8'h5b: v = 8'hc9;
      `RSQ_A_CALEN: v = 8'h17 | (8'h01 << `RSQ_CALEN_BIT);
      8'h59: v = 8'h49;
      8'h58: v = 8'h53;
      8'h57: v = 8'h45;
      `RSQ_A_FEEDBACK_DIVIDER: v = 8'h7d;
      8'h54: v = 8'h90;
      8'h53: v = 8'h19;
      8'h52, 8'h50, 8'h4e, 8'h4c, 8'h4a, 8'h48, 8'h46, 8'h44, 8'h42, 8'h40: v = 8'he9;
      8'h3c: v = 8'hff;
      8'h3b: v = 8'hfc;
      8'h37: v = 8'h02;
      8'h35: v = 8'h05;
      8'h34: v = 8'h24;
      8'h33, 8'h32: v = 8'h1d;
      8'h31: v = 8'h45;
      8'h16: v = 8'h06;
      8'h11, 8'h10: v = 8'h1f;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    d = q;
    go = 1'b0;
    go_rw = 1'b0;
    go_stream = 1'b0;
    go_strap = 4'h0;
    go_addr = 8'h00;
    go_byte = 8'h00;
    tick = (q.div == 8'(`RSQ_SCLK_HALF_CYC - 1));
    d.di_s = {q.di_s[1:0], spi.sdio};
    d.di_f = rsq_pkg::sync_filt(q.di_s, q.di_f);
    d.fin = 1'b0;
    d.rdata = 8'h00;

    if (sw_rd) begin
      case (sw_addr)
        `RSQ_H_CTRL: d.rdata = {6'h00, q.single, 1'b0};
        `RSQ_H_STAT: d.rdata = {6'h00, (q.st == rsq_pkg::H_DONE), (q.st != rsq_pkg::H_IDLE && q.st != rsq_pkg::H_DONE)};
        `RSQ_H_STRAP: d.rdata = {4'h0, q.strap};
        default: d.rdata = 8'h00;
      endcase
    end
    if (sw_wr && sw_addr == `RSQ_H_STRAP) begin
      d.strap = sw_wdata[3:0];
    end

    // each step launches a frame per pass; on the engine's end it moves on, or repeats for the next load address or an unfinished poll
    case (q.st)
      rsq_pkg::H_IDLE, rsq_pkg::H_DONE: begin
        if (sw_wr && sw_addr == `RSQ_H_CTRL && sw_wdata[`RSQ_CTRL_START]) begin
          d.single = sw_wdata[`RSQ_CTRL_SINGLE];
          d.st = rsq_pkg::H_RST;
        end
      end
      rsq_pkg::H_RST: begin
        go_addr = `RSQ_A_CFG;
        go_byte = `RSQ_CFG_RST_MASK;
        if (q.fin) begin
          d.st = rsq_pkg::H_CF;
        end else begin
          go = 1'b1;
        end
      end
      rsq_pkg::H_CF: begin
        go_addr = `RSQ_A_CFG;
        go_byte = 8'h00;
        if (q.fin) begin
          d.st = rsq_pkg::H_XF;
        end else begin
          go = 1'b1;
        end
      end
      rsq_pkg::H_XF: begin
        go_addr = `RSQ_A_XFER;
        go_byte = {q.single, 7'h00};
        if (q.fin) begin
          d.st = rsq_pkg::H_LD;
          d.cur = `RSQ_A_TOP;
        end else begin
          go = 1'b1;
        end
      end
      rsq_pkg::H_LD: begin
        go_strap = q.strap;
        go_addr = q.cur;
        go_byte = image(q.cur);
        go_stream = !q.single;
        if (q.fin) begin
          if (q.cur == `RSQ_A_BOT) begin
            d.st = rsq_pkg::H_PB;
          end else begin
            d.cur = q.cur - 8'h01;
          end
        end else begin
          go = 1'b1;
        end
      end
      rsq_pkg::H_PB: begin
        go_rw = 1'b1;
        go_strap = q.strap;
        go_addr = `RSQ_A_BUSY;
        if (q.fin) begin
          if (!q.rx[0]) begin
            d.st = rsq_pkg::H_PL;
          end
        end else begin
          go = 1'b1;
        end
      end
      rsq_pkg::H_PL: begin
        go_rw = 1'b1;
        go_strap = q.strap;
        go_addr = `RSQ_A_LOCK;
        if (q.fin) begin
          if (q.rx[0]) begin
            d.st = rsq_pkg::H_DONE;
          end
        end else begin
          go = 1'b1;
        end
      end
      default: begin
        d.st = rsq_pkg::H_IDLE;
      end
    endcase

    case (q.eng)
      rsq_pkg::E_IDLE: begin
        d.div = 8'h00;
        if (go) begin
          d.eng = rsq_pkg::E_RUN;
          d.csel = 1'b1;
          d.sclk = 1'b0;
          d.rw = go_rw;
          d.stream = go_stream;
          d.sh = {instr(go_rw, go_strap, go_addr), go_byte};
          d.dout = d.sh[23];
          d.doe = 1'b1;
          d.bitn = 5'd23;
        end
      end
      rsq_pkg::E_RUN: begin
        d.div = tick ? 8'h00 : q.div + 8'h01;
        if (tick && !q.sclk) begin
          d.sclk = 1'b1;
          d.rx = {q.rx[6:0], q.di_f};
        end else if (tick) begin
          d.sclk = 1'b0;
          if (q.bitn != 5'd0) begin
            d.sh = {q.sh[22:0], 1'b0};
            d.dout = d.sh[23];
            d.bitn = q.bitn - 5'd1;
            // instruction done: hand the data pin to the device for the read byte
            if (q.rw && q.bitn == 5'd8) begin
              d.doe = 1'b0;
            end
          end else if (q.stream && q.cur != `RSQ_A_BOT) begin
            d.cur = q.cur - 8'h01;
            d.sh[23:16] = image(q.cur - 8'h01);
            d.dout = d.sh[23];
            d.bitn = 5'd7;
          end else begin
            d.eng = rsq_pkg::E_END;
          end
        end
      end
      rsq_pkg::E_END: begin
        d.div = tick ? 8'h00 : q.div + 8'h01;
        if (tick) begin
          d.csel = 1'b0;
          d.doe = 1'b0;
          d.eng = rsq_pkg::E_GAP;
        end
      end
      rsq_pkg::E_GAP: begin
        // the gap lets the device see the deselect and release the pin first
        d.div = tick ? 8'h00 : q.div + 8'h01;
        if (tick) begin
          d.eng = rsq_pkg::E_IDLE;
          d.fin = 1'b1;
        end
      end
      default: begin
        d.eng = rsq_pkg::E_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign spi.cs_n = !q.csel;
  assign spi.sclk = q.sclk;
  assign spi.host_dio_o = q.dout;
  assign spi.host_dio_oe = q.doe;
  assign sw_rdata = q.rdata;
endmodule

// file: testbench/rsq_spi_assertions.sv
`timescale 1ns/1ps
module rsq_spi_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic host_dio_oe,
  input wire logic dev_dio_oe,
  input wire logic sdo_oe,
  input wire logic cal_busy,
  input wire logic loop_lock_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // five cycles cover the three-stage chip-select filter and the release register
  sequence s_idle; cs_n [*5]; endsequence
  sequence s_cal_start; $rose(cal_busy); endsequence
  property p_sdo_idle; s_idle |-> !sdo_oe; endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("serial output driven while deselected");
  property p_dio_idle; s_idle |-> !dev_dio_oe; endproperty
  a_dio_idle: assert property (p_dio_idle)
    else $error("data pin driven while deselected");
  // the bench never selects 4-wire, so the output stays released
  property p_sdo_3w; !sdo_oe; endproperty
  a_sdo_3w: assert property (p_sdo_3w)
    else $error("serial output driven in 3-wire mode");
  property p_no_clash; !(host_dio_oe && dev_dio_oe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data pin");
  property p_por; $rose(resetn) |-> !cal_busy && !loop_lock_flag; endproperty
  a_por: assert property (p_por)
    else $error("status not at default after reset");
  property p_cal_min; s_cal_start |-> cal_busy [*8]; endproperty
  a_cal_min: assert property (p_cal_min)
    else $error("calibration busy too short");
  property p_cal_end; s_cal_start |-> ##[1:1000] !cal_busy; endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration busy never ends");
  property p_lock_after; cal_busy |-> !loop_lock_flag; endproperty
  a_lock_after: assert property (p_lock_after)
    else $error("lock reported during calibration");
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
`include "rsq_consts.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ref_src = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic [3:0] strap = 4'h0;
  logic cal_busy;
  logic loop_lock_flag;
  integer seed = 51;
  integer fails = 0;
  integer n_compared = 0;
  rsq_spi_if rsq_spi_if_i ();
  rsq_device rsq_device_i (.ref_clk(ref_clk), .resetn(resetn), .spi(rsq_spi_if_i), .id_strap_bit0(strap[0]),
    .id_strap_bit1(strap[1]), .id_strap_bit2(strap[2]), .id_strap_bit3(strap[3]),
    .reference_clock_input(ref_src), .loop_lock_flag(loop_lock_flag), .cal_busy(cal_busy));
  rsq_host rsq_host_i (.ref_clk(ref_clk), .resetn(resetn), .spi(rsq_spi_if_i), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  rsq_spi_assertions rsq_spi_assertions_i (.ref_clk(ref_clk), .resetn(resetn), .cs_n(rsq_spi_if_i.cs_n),
    .host_dio_oe(rsq_spi_if_i.host_dio_oe), .dev_dio_oe(rsq_spi_if_i.dev_dio_oe),
    .sdo_oe(rsq_spi_if_i.sdo_oe), .cal_busy(cal_busy), .loop_lock_flag(loop_lock_flag));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // reference clock runs from time zero, before any initialisation
  initial begin
    forever #60 ref_src = ~ref_src;
  end
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // bounded wait on calibration busy or on lock
  task automatic wait_for(input bit lock, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge ref_clk);
      if ((lock ? loop_lock_flag : cal_busy) === 1'b1) break;
    end
    if (i == lim) begin
      fails++;
      close_out();
    end
  endtask
  // bounded poll of the sequencer status until it reports done
  task automatic wait_done(input int lim);
    logic [7:0] s;
    int i;
    s = 8'h00;
    for (i = 0; i < lim; i++) begin
      sw_read(`RSQ_H_STAT, s);
      if (s[1] === 1'b1) break;
    end
    if (i == lim) begin
      fails++;
      close_out();
    end
  endtask
  task automatic run(input logic [7:0] ctrl);
    logic [7:0] d;
    sw_write(`RSQ_H_STRAP, {4'h0, strap});
    sw_read(`RSQ_H_STRAP, d);
    chk("strap", {4'h0, strap}, d);
    sw_write(`RSQ_H_CTRL, ctrl);
    sw_read(`RSQ_H_CTRL, d);
    chk("mode", {6'h00, ctrl[`RSQ_CTRL_SINGLE], 1'b0}, d);
    wait_for(1'b0, 60000);
    wait_for(1'b1, 20000);
    chk("lock", 8'h01, {7'h00, loop_lock_flag});
    chk("busy", 8'h00, {7'h00, cal_busy});
    wait_done(30000);
    sw_read(`RSQ_H_STAT, d);
    chk("stat", 8'h02, d);
  endtask
  initial begin
    strap = 4'($random(seed));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    run(8'h01);
    // second reset after the first run completes must clear lock
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("lock_rst", 8'h00, {7'h00, loop_lock_flag});
    strap <= 4'($random(seed));
    @(posedge ref_clk);
    resetn <= 1'b1;
    run(8'h03);
    close_out();
  end
endmodule
